// >>> fces_sequencer.sv
// whole-array erase and program/erase suspend sequencing of a serial flash
// assumes mosi/csN/sclk from the host; verify, protect and read address come
// from neighbouring logic on mclk
`timescale 1ns/1ps

module fces_sequencer #(
  parameter int CHIP_ERASE_US = 2000,
  parameter int BLK_ERASE_US  = 500,
  parameter int PROG_US       = 100
) (
  // system
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // serial link
  input  wire logic                  sclk,
  input  wire logic                  csN,
  input  wire logic                  mosi,
  // neighbouring logic, mclk domain
  input  wire logic                  anySectorLocked,
  input  wire logic                  verifyFail,
  input  wire logic                  swReset,
  input  wire logic [23:0]           readAddr,
  // status
  output logic                       writeEnableLatch,
  output logic                       readyBusyFlag,
  output logic                       programEraseErrorFlag,
  output logic                       programSuspendedFlag,
  output logic                       eraseSuspendedFlag,
  output logic                       readUndefined,
  output logic                       suspBlockLost,
  output logic                       suspPageLost
);

  localparam int CHIP_CYC = CHIP_ERASE_US * fces_pkg::MCLK_PER_US;
  localparam int BLK_CYC  = BLK_ERASE_US * fces_pkg::MCLK_PER_US;
  localparam int PROG_CYC = PROG_US * fces_pkg::MCLK_PER_US;

  function automatic logic cmdAllowed(
    input logic [7:0] opc,
    input logic       ps,
    input logic       es
  );
    logic ok;
    ok = 1'b1;
    if (ps || es)
    begin
      case (opc)
        fces_pkg::OPC_CHIP_A, fces_pkg::OPC_CHIP_B,
        fces_pkg::OPC_BLK4, fces_pkg::OPC_BLK32,
        fces_pkg::OPC_BLK64, fces_pkg::OPC_PROT:
          ok = 1'b0;
        fces_pkg::OPC_PROG, fces_pkg::OPC_SUSP,
        fces_pkg::OPC_WREN, fces_pkg::OPC_WRDI:
          ok = !ps;
        default:
          ok = 1'b1;
      endcase
    end
    return ok;
  endfunction : cmdAllowed

  // ---------------- link domain ----------------
  logic [7:0]               shift_q;
  logic [7:0]               opc_q;
  logic [2:0]               bitMod_q;
  logic [2:0]               byteCnt_q;
  logic [fces_pkg::SEC_W-1:0] sec_q;
  logic                     fresh_q;
  logic                     seenTog_q;

  // frame start marker: set while deselected, gone at first edge
  always_ff @(posedge sclk or posedge csN or posedge rst)
  begin
    if (rst || csN)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // shifter keeps its result after deselect; sclk is still then,
  // so mclk may read it once the synchronised deselect arrives
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      shift_q   <= 8'h00;
      opc_q     <= 8'h00;
      bitMod_q  <= 3'h0;
      byteCnt_q <= 3'h0;
      sec_q     <= '0;
      seenTog_q <= 1'b0;
    end
    else
    begin
      shift_q  <= {shift_q[6:0], mosi};
      bitMod_q <= fresh_q ? 3'h1 : bitMod_q + 3'h1;
      if (fresh_q)
      begin
        byteCnt_q <= 3'h0;
        seenTog_q <= !seenTog_q;
      end
      else if (bitMod_q == fces_pkg::BIT_LAST)
      begin
        if (byteCnt_q != fces_pkg::BYTES_DATA)
          byteCnt_q <= byteCnt_q + 3'h1; // trailing bytes ignored
        if (byteCnt_q == 3'h0)
          opc_q <= {shift_q[6:0], mosi};
        if (byteCnt_q == fces_pkg::BYTES_OPC)
          sec_q <= {shift_q[fces_pkg::SEC_W-2:0], mosi};
      end
    end
  end

  // ---------------- crossing ----------------
  logic csS1_q;
  logic csS2_q;
  logic csS3_q;
  logic lastTog_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      csS1_q <= 1'b1;
      csS2_q <= 1'b1;
      csS3_q <= 1'b1;
    end
    else
    begin
      csS1_q <= csN;
      csS2_q <= csS1_q;
      csS3_q <= csS2_q;
    end
  end

  // a deselect with no clock edges carries no new frame
  logic frameEnd;
  assign frameEnd = csS2_q && !csS3_q && (seenTog_q != lastTog_q);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      lastTog_q <= 1'b0;
    else if (csS2_q && !csS3_q)
      lastTog_q <= seenTog_q;
  end

  // ---------------- command decode ----------------
  fces_pkg::fces_state_t st_q;
  fces_pkg::fces_op_t    op_q;
  logic                  wel_q;
  logic                  ps_q;
  logic                  es_q;

  logic aligned;
  logic opcSeen;
  logic allowed;
  logic idle;
  logic isChip;
  logic isBlk;
  logic isProg;
  logic cmdEnd;
  logic full;
  logic blkConflict;
  logic progConflict;
  logic eraseAll_q;
  logic [fces_pkg::SEC_W-1:0] progSec_q;
  logic [fces_pkg::SEC_W-1:0] eraseSec_q;

  assign aligned = (bitMod_q == 3'h0);
  assign opcSeen = (byteCnt_q >= fces_pkg::BYTES_OPC);
  assign allowed = cmdAllowed(opc_q, ps_q, es_q);
  assign idle    = (st_q == fces_pkg::ST_IDLE);
  assign cmdEnd  = frameEnd && opcSeen && allowed && idle;
  assign full    = cmdEnd && aligned;
  assign isChip  = (opc_q == fces_pkg::OPC_CHIP_A)
                || (opc_q == fces_pkg::OPC_CHIP_B);
  assign isBlk   = (opc_q == fces_pkg::OPC_BLK4)
                || (opc_q == fces_pkg::OPC_BLK32)
                || (opc_q == fces_pkg::OPC_BLK64);
  assign isProg  = (opc_q == fces_pkg::OPC_PROG);
  assign blkConflict  = ps_q && (sec_q == progSec_q);
  assign progConflict = es_q && (eraseAll_q || sec_q == eraseSec_q);

  logic startChip;
  logic startBlk;
  logic startProg;
  logic clrWel;
  logic suspReq;
  logic resReq;

  assign startChip = full && isChip && wel_q && !anySectorLocked;
  assign startBlk  = full && isBlk && wel_q
                  && byteCnt_q >= fces_pkg::BYTES_ADDR && !blkConflict;
  assign startProg = full && isProg && wel_q
                  && byteCnt_q >= fces_pkg::BYTES_DATA && !progConflict;
  // uneven deselect, lock or sector conflict drop the latch
  assign clrWel = cmdEnd && (
      (isChip && (!aligned || anySectorLocked))
    || (isBlk && !startBlk)
    || (isProg && !startProg));
  // suspend and resume ignore the latch; short frames are dropped
  assign suspReq = frameEnd && aligned && opcSeen && allowed
                && opc_q == fces_pkg::OPC_SUSP;
  assign resReq  = full && opc_q == fces_pkg::OPC_RES && (ps_q || es_q);

  // ---------------- write enable latch ----------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      wel_q <= 1'b0;
    else if (swReset)
      wel_q <= 1'b0;
    else if (full && opc_q == fces_pkg::OPC_WREN)
      wel_q <= 1'b1;
    else if (full && opc_q == fces_pkg::OPC_WRDI)
      wel_q <= 1'b0;
    else if (clrWel || startChip || startBlk || startProg)
      wel_q <= 1'b0;
  end

  // ---------------- operation engine ----------------
  logic [fces_pkg::CNT_W-1:0] progLeft_q;
  logic [fces_pkg::CNT_W-1:0] eraseLeft_q;
  logic [fces_pkg::LAT_W-1:0] lat_q;
  logic                       busy_q;
  logic                       runLast;
  logic                       opDone;

  assign runLast = (op_q == fces_pkg::OP_PROG) ? (progLeft_q == 1)
                                               : (eraseLeft_q == 1);
  assign opDone  = runLast && (st_q == fces_pkg::ST_RUN
                            || st_q == fces_pkg::ST_SUSP);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q        <= fces_pkg::ST_IDLE;
      op_q        <= fces_pkg::OP_NONE;
      progLeft_q  <= '0;
      eraseLeft_q <= '0;
      lat_q       <= '0;
      busy_q      <= 1'b0;
      ps_q        <= 1'b0;
      es_q        <= 1'b0;
      eraseAll_q  <= 1'b0;
      progSec_q   <= '0;
      eraseSec_q  <= '0;
    end
    else if (swReset)
    begin
      // suspended work is abandoned, not resumed
      st_q   <= fces_pkg::ST_IDLE;
      op_q   <= fces_pkg::OP_NONE;
      busy_q <= 1'b0;
      ps_q   <= 1'b0;
      es_q   <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        fces_pkg::ST_IDLE:
        begin
          if (startChip || startBlk)
          begin
            st_q        <= fces_pkg::ST_RUN;
            op_q        <= fces_pkg::OP_ERASE;
            busy_q      <= 1'b1;
            eraseAll_q  <= startChip;
            eraseSec_q  <= sec_q;
            eraseLeft_q <= startChip ? fces_pkg::CNT_W'(CHIP_CYC)
                                     : fces_pkg::CNT_W'(BLK_CYC);
          end
          else if (startProg)
          begin
            st_q       <= fces_pkg::ST_RUN;
            op_q       <= fces_pkg::OP_PROG;
            busy_q     <= 1'b1;
            progSec_q  <= sec_q;
            progLeft_q <= fces_pkg::CNT_W'(PROG_CYC);
          end
          else if (resReq)
          begin
            st_q   <= fces_pkg::ST_RES;
            busy_q <= 1'b1;
            lat_q  <= fces_pkg::LAT_W'(fces_pkg::RES_CYC);
            op_q   <= ps_q ? fces_pkg::OP_PROG : fces_pkg::OP_ERASE;
          end
        end
        fces_pkg::ST_RUN, fces_pkg::ST_SUSP:
        begin
          if (op_q == fces_pkg::OP_PROG)
            progLeft_q <= progLeft_q - 1'b1;
          else
            eraseLeft_q <= eraseLeft_q - 1'b1;
          if (runLast)
          begin
            // finishing beats a pending suspend
            st_q   <= fces_pkg::ST_IDLE;
            op_q   <= fces_pkg::OP_NONE;
            busy_q <= 1'b0;
          end
          else if (st_q == fces_pkg::ST_RUN && suspReq)
          begin
            st_q  <= fces_pkg::ST_SUSP;
            lat_q <= fces_pkg::LAT_W'(fces_pkg::SUSP_CYC);
          end
          else if (st_q == fces_pkg::ST_SUSP && lat_q == 1)
          begin
            st_q   <= fces_pkg::ST_IDLE;
            op_q   <= fces_pkg::OP_NONE;
            busy_q <= 1'b0;
            if (op_q == fces_pkg::OP_PROG)
              ps_q <= 1'b1;
            else
              es_q <= 1'b1;
          end
          else if (st_q == fces_pkg::ST_SUSP)
            lat_q <= lat_q - 1'b1;
        end
        fces_pkg::ST_RES:
        begin
          // a suspend arriving here is dropped: state is not RUN
          if (lat_q == 1)
          begin
            st_q <= fces_pkg::ST_RUN;
            if (op_q == fces_pkg::OP_PROG)
              ps_q <= 1'b0;
            else
              es_q <= 1'b0;
          end
          else
            lat_q <= lat_q - 1'b1;
        end
        default:
        begin
          st_q   <= fces_pkg::ST_IDLE;
          op_q   <= fces_pkg::OP_NONE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- error flag ----------------
  logic epe_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      epe_q <= 1'b0;
    else if (opDone && !swReset && verifyFail)
      epe_q <= 1'b1;
    else if (startChip || startBlk || startProg)
      epe_q <= 1'b0;
  end

  // ---------------- read guard and reset losses ----------------
  logic readUndef_q;
  logic blkLost_q;
  logic pageLost_q;
  logic [fces_pkg::SEC_W-1:0] readSec;

  assign readSec = readAddr[fces_pkg::SEC_MSB:fces_pkg::SEC_LSB];

  // checked every cycle so a sequential read tracks sector crossings
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      readUndef_q <= 1'b0;
    else
      readUndef_q <= (es_q && (eraseAll_q || readSec == eraseSec_q))
                  || (ps_q && readSec == progSec_q);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      blkLost_q  <= 1'b0;
      pageLost_q <= 1'b0;
    end
    else if (swReset)
    begin
      blkLost_q  <= es_q;
      pageLost_q <= ps_q;
    end
  end

  assign writeEnableLatch      = wel_q;
  assign readyBusyFlag         = busy_q;
  assign programEraseErrorFlag = epe_q;
  assign programSuspendedFlag  = ps_q;
  assign eraseSuspendedFlag    = es_q;
  assign readUndefined         = readUndef_q;
  assign suspBlockLost         = blkLost_q;
  assign suspPageLost          = pageLost_q;

endmodule : fces_sequencer

// >>> fces_pkg.sv
// constants, opcodes and state types of the erase/suspend sequencer
// assumes a 10 MHz system clock and a host-driven serial clock
package fces_pkg;

  localparam int MCLK_HZ = 10_000_000;
  localparam int MCLK_PER_US = MCLK_HZ / 1_000_000;

  // opcodes
  localparam logic [7:0] OPC_WREN   = 8'h06;
  localparam logic [7:0] OPC_WRDI   = 8'h04;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hc7;
  localparam logic [7:0] OPC_SUSP   = 8'hb0;
  localparam logic [7:0] OPC_RES    = 8'hd0;
  localparam logic [7:0] OPC_PROG   = 8'ha2;
  localparam logic [7:0] OPC_BLK4   = 8'h20;
  localparam logic [7:0] OPC_BLK32  = 8'h52;
  localparam logic [7:0] OPC_BLK64  = 8'hd8;
  localparam logic [7:0] OPC_PROT   = 8'h36;

  // frame geometry: byte counter saturates at opcode + 3 address + 1 data
  localparam logic [2:0] BYTES_OPC  = 3'h1;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_DATA = 3'h5;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam int SEC_MSB = 22;
  localparam int SEC_LSB = 16;
  localparam int SEC_W   = SEC_MSB - SEC_LSB + 1;
  localparam int CNT_W   = 24;
  localparam int LAT_W   = 16;

  // latencies, longest times, so rounded down
  localparam int SUSP_LAT_NS = 20000;
  localparam int RES_LAT_NS  = 20000;
  localparam int SUSP_CYC = (SUSP_LAT_NS * MCLK_PER_US) / 1000;
  localparam int RES_CYC  = (RES_LAT_NS * MCLK_PER_US) / 1000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_SUSP = 4'b0100,
    ST_RES  = 4'b1000
  } fces_state_t;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10
  } fces_op_t;

endpackage : fces_pkg

// >>> fces_host_model.sv
// host serial master model: frames bits on sclk/csN/mosi, msb first
// spaces frames itself, 500 ns deselected; sclk stands low outside frames
`timescale 1ns/1ps

module fces_host_model (
  // serial link
  output logic sclk,
  output logic csN,
  output logic mosi
);

  initial
  begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b1;
  end

  // sends the top nb bits of d; 30 ns link clock only inside the frame
  task automatic frame(input logic [39:0] d, input int nb);
    csN = 1'b0;
    #20;
    for (int i = 0; i < nb; i++)
    begin
      mosi = d[39-i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    // released line: no pull, so show the inverse rather than a stale bit
    mosi = ~mosi;
    #15 csN = 1'b1;
    // deselect spacing one system cycle above the four asked for
    #500;
  endtask : frame

endmodule : fces_host_model

// >>> fces_sequencer_assertions.sv
// status output checks of the erase/suspend sequencer
// sees only the sequencer ports; bound at the foot of this file
`timescale 1ns/1ps

module fces_sequencer_assertions (
  input logic        mclk,
  input logic        rst,
  input logic        sclk,
  input logic        csN,
  input logic        mosi,
  input logic        anySectorLocked,
  input logic        verifyFail,
  input logic        swReset,
  input logic [23:0] readAddr,
  input logic        writeEnableLatch,
  input logic        readyBusyFlag,
  input logic        programEraseErrorFlag,
  input logic        programSuspendedFlag,
  input logic        eraseSuspendedFlag,
  input logic        readUndefined,
  input logic        suspBlockLost,
  input logic        suspPageLost
);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_start_clr_latch : assert property (
    $rose(readyBusyFlag) && !programSuspendedFlag && !eraseSuspendedFlag |-> !writeEnableLatch)
    else $error("latch still set at op start");
  a_start_clr_error : assert property (
    $rose(readyBusyFlag) && !programSuspendedFlag && !eraseSuspendedFlag
    |-> !programEraseErrorFlag) else $error("error flag kept at op start");
  a_susp_ready : assert property (
    $rose(programSuspendedFlag) || $rose(eraseSuspendedFlag) |-> !readyBusyFlag)
    else $error("busy while suspended");
  a_susp_from_busy : assert property (
    $rose(programSuspendedFlag) || $rose(eraseSuspendedFlag) |-> $past(readyBusyFlag))
    else $error("suspend without running op");
  a_swreset_idle : assert property (
    swReset |=> !readyBusyFlag && !programSuspendedFlag && !eraseSuspendedFlag
    && !writeEnableLatch) else $error("reset left state");
  a_swreset_lost : assert property (
    swReset |=> suspBlockLost == $past(eraseSuspendedFlag)
    && suspPageLost == $past(programSuspendedFlag)) else $error("lost flags wrong");
  a_undef_needs_susp : assert property (
    readUndefined |-> $past(programSuspendedFlag) || $past(eraseSuspendedFlag))
    else $error("undefined read with no suspend");
  a_resume_clears : assert property (
    $rose(readyBusyFlag) && programSuspendedFlag |-> ##[1:205] $fell(programSuspendedFlag))
    else $error("resume did not clear flag");
  a_busy_bounded : assert property (
    $rose(readyBusyFlag) |-> ##[1:900] !readyBusyFlag) else $error("busy never ends");

  c_both_susp : cover property (programSuspendedFlag && eraseSuspendedFlag);
  c_erase_err : cover property ($rose(programEraseErrorFlag));
  c_lost_blk  : cover property ($rose(suspBlockLost));
  c_lost_page : cover property ($rose(suspPageLost));

endmodule : fces_sequencer_assertions

bind fces_sequencer fces_sequencer_assertions u_chk (
  .mclk, .rst, .sclk, .csN, .mosi, .anySectorLocked, .verifyFail, .swReset, .readAddr,
  .writeEnableLatch, .readyBusyFlag, .programEraseErrorFlag, .programSuspendedFlag,
  .eraseSuspendedFlag, .readUndefined, .suspBlockLost, .suspPageLost
);

// >>> fces_sequencer_tb.sv
// self-checking bench of the erase/suspend sequencer
// host model drives the link; op times shortened so a run stays short
`timescale 1ns/1ps

module fces_sequencer_tb;

  localparam logic [39:0] W = 40'h0600000000;
  logic        mclk, rst, anySectorLocked, verifyFail, swReset;
  logic [23:0] readAddr;
  logic        sclk, csN, mosi, write_enable_latch, busy, program_erase_error_flag, ps, es, undef, bLost, pLost;
  logic [2:0]  st;
  logic [31:0] seed;
  logic [6:0]  sec;
  int          failures, checks;

  assign st = {busy, ps, es};

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  fces_host_model host (.sclk(sclk), .csN(csN), .mosi(mosi));

  fces_sequencer #(.CHIP_ERASE_US(50), .BLK_ERASE_US(60), .PROG_US(30)) dut (
    .mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi),
    .anySectorLocked(anySectorLocked), .verifyFail(verifyFail), .swReset(swReset),
    .readAddr(readAddr), .writeEnableLatch(write_enable_latch), .readyBusyFlag(busy),
    .programEraseErrorFlag(program_erase_error_flag), .programSuspendedFlag(ps), .eraseSuspendedFlag(es),
    .readUndefined(undef), .suspBlockLost(bLost), .suspPageLost(pLost)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : chk

  // read outputs just after the edge, once its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic cmd(input logic [39:0] d, input int nb);
    host.frame(d, nb);
    cyc(6);
  endtask : cmd

  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    while (st[k] !== v && n < 1500)
    begin
      cyc(1);
      n++;
    end
    chk(st[k], v);
  endtask : wt

  // expected undefined-read flag for a read of sector s
  function automatic logic undefExp(
    input logic [6:0] s,
    input logic [6:0] suspSec,
    input logic       all
  );
    return all || (s == suspSec);
  endfunction : undefExp

  // one-cycle software reset, outputs read after it lands
  task automatic swPulse;
    @(posedge mclk) swReset <= 1'b1;
    @(posedge mclk) swReset <= 1'b0;
    cyc(1);
  endtask : swPulse

  task automatic test_done;
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    #2_000_000;
    failures++;
    test_done();
  end

  initial
  begin
    rst = 1'b1;
    swReset = 1'b0;
    anySectorLocked = 1'b0;
    verifyFail = 1'b0;
    readAddr = 24'h000000;
    seed = 32'he245ab92;
    failures = 0;
    checks = 0;
    cyc(3);
    @(posedge mclk) rst <= 1'b0;
    cyc(2);
    chk(write_enable_latch, 1'b0);
    chk(busy, 1'b0);
    chk(ps, 1'b0);
    chk(es, 1'b0);
    cmd(40'h6000000000, 8);
    chk(busy, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      @(posedge mclk) verifyFail <= seed[0];
      cmd(W, 8);
      chk(write_enable_latch, 1'b1);
      cmd({i[0] ? 8'hc7 : 8'h60, seed}, 16);
      chk(busy, 1'b1);
      chk(write_enable_latch, 1'b0);
      wt(2, 1'b0);
      chk(program_erase_error_flag, seed[0]);
    end
    @(posedge mclk) verifyFail <= 1'b0;
    cmd(W, 8);
    cmd(40'hc700000000, 12);
    chk(write_enable_latch, 1'b0);
    chk(busy, 1'b0);
    @(posedge mclk) anySectorLocked <= 1'b1;
    cmd(W, 8);
    cmd(40'h6000000000, 8);
    chk(write_enable_latch, 1'b0);
    chk(busy, 1'b0);
    @(posedge mclk) anySectorLocked <= 1'b0;
    // suspend a block erase in sector 5; a short suspend first
    seed = lfsr(seed);
    cmd(W, 8);
    cmd({seed[0] ? 8'h52 : 8'h20, 32'h05000000}, 32);
    chk(busy, 1'b1);
    cmd(40'hb000000000, 6);
    chk(busy, 1'b1);
    chk(es, 1'b0);
    cmd(40'hb0ff000000, 16);
    wt(0, 1'b1);
    chk(busy, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      sec = i[0] ? 7'h05 : seed[22:16];
      @(posedge mclk) readAddr <= {seed[23], sec, seed[15:0]};
      cyc(3);
      chk(undef, undefExp(sec, 7'h05, 1'b0));
    end
    cmd(W, 8);
    chk(write_enable_latch, 1'b1);
    cmd(40'h3600000000, 32);
    chk(write_enable_latch, 1'b1);
    cmd(40'h6000000000, 8);
    chk(busy, 1'b0);
    chk(write_enable_latch, 1'b1);
    cmd(40'h0400000000, 8);
    chk(write_enable_latch, 1'b0);
    cmd(W, 8);
    cmd(40'ha205000055, 40);
    chk(busy, 1'b0);
    chk(write_enable_latch, 1'b0);
    cmd(W, 8);
    cmd(40'ha209000055, 40);
    chk(busy, 1'b1);
    cmd(40'hb000000000, 8);
    wt(1, 1'b1);
    chk(es, 1'b1);
    cmd(W, 8);
    chk(write_enable_latch, 1'b0);
    cmd(40'hd809000000, 32);
    chk(busy, 1'b0);
    chk(write_enable_latch, 1'b0);
    cmd(40'hd000000000, 8);
    chk(busy, 1'b1);
    wt(1, 1'b0);
    chk(es, 1'b1);
    wt(2, 1'b0);
    chk(es, 1'b1);
    cmd(40'hd000000000, 8);
    chk(busy, 1'b1);
    wt(0, 1'b0);
    wt(2, 1'b0);
    chk(program_erase_error_flag, 1'b0);
    // software reset while a whole-array erase is suspended
    cmd(W, 8);
    cmd(40'h6000000000, 8);
    cmd(40'hb000000000, 8);
    wt(0, 1'b1);
    seed = lfsr(seed);
    sec = seed[22:16];
    @(posedge mclk) readAddr <= {seed[23], sec, seed[15:0]};
    cyc(3);
    chk(undef, undefExp(sec, 7'h05, 1'b1));
    cmd(W, 8);
    cmd({8'ha2, seed}, 40);
    chk(busy, 1'b0);
    chk(write_enable_latch, 1'b0);
    swPulse();
    chk(es, 1'b0);
    chk(bLost, 1'b1);
    chk(pLost, 1'b0);
    // reset with both suspended: block and page both lost
    cmd(W, 8);
    cmd(40'h5203000000, 32);
    cmd(40'hb000000000, 8);
    wt(0, 1'b1);
    cmd(W, 8);
    cmd(40'ha204000012, 40);
    cmd(40'hb000000000, 8);
    wt(1, 1'b1);
    swPulse();
    chk(ps, 1'b0);
    chk(bLost, 1'b1);
    chk(pLost, 1'b1);
    test_done();
  end

endmodule : fces_sequencer_tb
